//--- design/tud_edge.sv
// falling edge detector for synchronous pins
// assumes inputs already synchronous to i_clk
`timescale 1ns/1ps
module tud_edge #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // pins and edges
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_fall
);
  logic [W-1:0] prev_reg;

  // previous level, idle high
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prev_reg <= {W{1'b1}};
    end else begin
      prev_reg <= i_pin;
    end
  end
  assign o_fall = prev_reg & ~i_pin;
endmodule

//--- design/tud_map.svh
// register addresses, field positions, reset values and counts
// assumes inclusion by the prescaler, timer and bench files
`ifndef TUD_MAP_SVH
`define TUD_MAP_SVH

// ************************************************************
// register addresses
// ************************************************************
`define TUD_ADR_SPEED   8'h8F
`define TUD_ADR_CTRL    8'hC8
`define TUD_ADR_MODE    8'hC9
`define TUD_ADR_RLD_LO  8'hCA
`define TUD_ADR_RLD_HI  8'hCB
`define TUD_ADR_CNT_LO  8'hCC
`define TUD_ADR_CNT_HI  8'hCD

// ************************************************************
// field positions
// ************************************************************
`define TUD_B_DOUBLE    0
`define TUD_B_OVF       7
`define TUD_B_EXT       6
`define TUD_B_RCLK      5
`define TUD_B_TRANSMIT_CLOCK_SELECT      4
`define TUD_B_EXEN      3
`define TUD_B_RUN       2
`define TUD_B_CSEL      1
`define TUD_B_CPRL      0
`define TUD_B_UDEN      0

// ************************************************************
// reset values and counts
// ************************************************************
`define TUD_RST_BYTE    8'h00
`define TUD_RST_WORD    16'h0000
`define TUD_CNT_MAX     16'hFFFF
`define TUD_XTAL_STD    12
`define TUD_XTAL_X2     6
`define TUD_MC_DIV      4'hC
`endif

//--- design/tud_pkg.sv
// types shared by the timer design files
// assumes nothing of its surroundings
package tud_pkg;
  // operating mode, gray coded along capture-reload-updown-baud
  typedef enum logic [1:0] {
    TUD_CAPTURE = 2'b00,
    TUD_RELOAD  = 2'b01,
    TUD_UPDOWN  = 2'b11,
    TUD_BAUD    = 2'b10
  } tud_mode_t;
endpackage

//--- design/tud_prescale.sv
// core clock enable and machine cycle tick generator
// assumes i_clk is the crystal clock
`timescale 1ns/1ps
`include "tud_map.svh"
module tud_prescale (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // speed select
  input  wire logic i_double,
  // enables
  output logic      o_core_en,
  output logic      o_mc_tick
);
  logic       phase_reg;
  logic [3:0] div_reg;

  // core clock: crystal halved, or full rate when doubled
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;
    end
  end
  assign o_core_en = i_double | phase_reg;

  // divide core clock by twelve
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_reg <= 4'h0;
    end else if (o_core_en) begin
      if (div_reg == `TUD_MC_DIV - 4'h1) begin
        div_reg <= 4'h0;
      end else begin
        div_reg <= div_reg + 4'h1;
      end
    end
  end
  assign o_mc_tick = o_core_en && (div_reg == `TUD_MC_DIV - 4'h1);

  // ************************************************************
  // checks
  // ************************************************************
  property p_std_half;
    @(posedge i_clk) disable iff (i_rst)
      (!i_double && o_core_en) ##1 !i_double |-> !o_core_en;
  endproperty
  a_std_half: assert property (p_std_half)
    else $error("core enable too fast in standard speed");

  // double speed: divider steps on every clock between ticks
  property p_x2_full;
    @(posedge i_clk) disable iff (i_rst)
      i_double && !o_mc_tick |=> div_reg == $past(div_reg) + 4'h1;
  endproperty
  a_x2_full: assert property (p_x2_full)
    else $error("machine cycle divider stalled in double speed");
endmodule

//--- design/tud_timer.sv
// 16-bit up/down auto-reload timer with speed control registers
// assumes a byte register port with one-cycle read and write strobes
`timescale 1ns/1ps
`include "tud_map.svh"
// Function
// - standard speed uses crystal/2 core clock, double speed full crystal.
// - reset leaves double speed bit clear, standard speed mode.
// - double speed halves time reference of every core-clocked event.
// - speed register bits 7..1 reserved; read zero, software writes zero.
// - count is two cascaded bytes; low byte carry advances high byte.
// - counter select picks core clock /12 or event pin.
// - count advances only while run control is set.
// - capture, auto-reload, baud modes from clock and reload selects.
// - up/down enable in reload mode: direction pin high up, low down.
// - up-count past FFFFh outside baud mode sets overflow flag and requests interrupt.
// - up-count overflow outside capture mode loads reload bytes into count bytes.
// - down-count equal to reload value sets flag, loads FFFFh.
// - up/down mode toggles external flag, no interrupt from it.
// - overflow flag set only with both clock selects zero; sticky.
// - counter operation advances on event pin falling edges.
// - no up/down, no baud, external enable: direction fall captures/reloads.
module tud_timer (
  // clock and reset
  input  wire logic       I_CLK,
  input  wire logic       I_RST,
  // register port
  input  wire logic [7:0] I_SFR_ADDR,
  input  wire logic       I_SFR_WR,
  input  wire logic       I_SFR_RD,
  input  wire logic [7:0] I_SFR_WDATA,
  output logic      [7:0] O_SFR_RDATA,
  // external pins
  input  wire logic       I_EVENT_COUNT_PIN,
  input  wire logic       I_DIRECTION_PIN,
  // status and time base
  output logic            O_IRQ,
  output logic            O_BAUD_OVF,
  output logic            O_DOUBLE_SPEED,
  output logic            O_CORE_EN,
  output logic            O_MC_TICK
);
  // ************************************************************
  // state
  // ************************************************************
  logic            double_speed_bit_reg;
  logic [7:0]      ctrl_reg;
  logic            up_down_enable_reg;
  logic [7:0]      count_low_byte_reg;
  logic [7:0]      count_high_byte_reg;
  logic [7:0]      reload_low_byte_reg;
  logic [7:0]      reload_high_byte_reg;
  logic            overflow_flag_reg;
  logic            external_flag_reg;
  logic [7:0]      rdata_reg;
  logic            baud_reg;
  logic [15:0]     cnt_next;
  logic [15:0]     cnt;
  logic [15:0]     rld;
  logic [1:0]      fall;
  logic            core_en;
  logic            mc_tick;
  tud_pkg::tud_mode_t mode;
  logic            baud;
  logic            updown;
  logic            reload_mode;
  logic            dir_up;
  logic            inc_ev;
  logic            ovf_ev;
  logic            unf_ev;
  logic            ext_ev;
  logic            capture;
  logic            reload_ext;
  logic            wr_ctrl;
  logic            wr_lo;
  logic            wr_hi;
  logic            wr_rlo;
  logic            wr_rhi;
  logic            wr_cnt;

  // write strobe for one address
  function automatic logic wr_at(input logic [7:0] a);
    return I_SFR_WR && (I_SFR_ADDR == a);
  endfunction

  // operating mode from clock selects, capture select and up/down enable
  function automatic tud_pkg::tud_mode_t decode(
    input logic [7:0] c,
    input logic       uden
  );
    if (c[`TUD_B_RCLK] || c[`TUD_B_TRANSMIT_CLOCK_SELECT]) begin
      return tud_pkg::TUD_BAUD;
    end else if (c[`TUD_B_CPRL]) begin
      return tud_pkg::TUD_CAPTURE;
    end else if (uden) begin
      return tud_pkg::TUD_UPDOWN;
    end else begin
      return tud_pkg::TUD_RELOAD;
    end
  endfunction

  // ************************************************************
  // time base and pin edges
  // ************************************************************
  tud_prescale u_pre (
    .i_clk     (I_CLK),
    .i_rst     (I_RST),
    .i_double  (double_speed_bit_reg),
    .o_core_en (core_en),
    .o_mc_tick (mc_tick)
  );

  tud_edge #(.W(2)) u_edge (
    .i_clk  (I_CLK),
    .i_rst  (I_RST),
    .i_pin  ({I_DIRECTION_PIN, I_EVENT_COUNT_PIN}),
    .o_fall (fall)
  );

  // ************************************************************
  // decode and events
  // ************************************************************
  assign wr_ctrl = wr_at(`TUD_ADR_CTRL);
  assign wr_lo   = wr_at(`TUD_ADR_CNT_LO);
  assign wr_hi   = wr_at(`TUD_ADR_CNT_HI);
  assign wr_rlo  = wr_at(`TUD_ADR_RLD_LO);
  assign wr_rhi  = wr_at(`TUD_ADR_RLD_HI);
  assign wr_cnt  = wr_lo | wr_hi;
  assign cnt     = {count_high_byte_reg, count_low_byte_reg};
  assign rld     = {reload_high_byte_reg, reload_low_byte_reg};

  // mode selection
  assign mode        = decode(ctrl_reg, up_down_enable_reg);
  assign baud        = (mode == tud_pkg::TUD_BAUD);
  assign updown      = (mode == tud_pkg::TUD_UPDOWN);
  assign reload_mode = (mode != tud_pkg::TUD_CAPTURE);
  assign dir_up      = ~updown | I_DIRECTION_PIN;

  // count input select, gated by run control
  assign inc_ev = ctrl_reg[`TUD_B_RUN] &&
                  (ctrl_reg[`TUD_B_CSEL] ? fall[0] : mc_tick);
  assign ovf_ev = inc_ev && dir_up && (cnt == `TUD_CNT_MAX);
  assign unf_ev = inc_ev && !dir_up && (cnt == rld);

  // direction pin fall events outside up/down mode
  assign ext_ev = ctrl_reg[`TUD_B_EXEN] && fall[1] && !updown;
  assign capture    = ext_ev && (mode == tud_pkg::TUD_CAPTURE);
  assign reload_ext = ext_ev && (mode == tud_pkg::TUD_RELOAD);

  // ************************************************************
  // count registers
  // ************************************************************
  // next count before software overrides
  always_comb begin
    cnt_next = cnt;
    if (reload_ext) begin
      cnt_next = rld;
    end else if (ovf_ev && reload_mode) begin
      cnt_next = rld;
    end else if (unf_ev) begin
      cnt_next = `TUD_CNT_MAX;
    end else if (inc_ev && dir_up) begin
      cnt_next[7:0]  = count_low_byte_reg + 8'h01;
      cnt_next[15:8] = count_high_byte_reg +
                       {7'h00, count_low_byte_reg == 8'hFF};
    end else if (inc_ev) begin
      cnt_next = cnt - 16'h0001;
    end
  end

  // count bytes, software write wins per byte
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      count_low_byte_reg  <= `TUD_RST_BYTE;
      count_high_byte_reg <= `TUD_RST_BYTE;
    end else begin
      count_low_byte_reg  <= wr_lo ? I_SFR_WDATA : cnt_next[7:0];
      count_high_byte_reg <= wr_hi ? I_SFR_WDATA : cnt_next[15:8];
    end
  end

  // reload bytes, capture on direction pin fall
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      reload_low_byte_reg  <= `TUD_RST_BYTE;
      reload_high_byte_reg <= `TUD_RST_BYTE;
    end else begin
      if (wr_rlo) begin
        reload_low_byte_reg <= I_SFR_WDATA;
      end else if (capture) begin
        reload_low_byte_reg <= count_low_byte_reg;
      end
      if (wr_rhi) begin
        reload_high_byte_reg <= I_SFR_WDATA;
      end else if (capture) begin
        reload_high_byte_reg <= count_high_byte_reg;
      end
    end
  end

  // ************************************************************
  // control and flags
  // ************************************************************
  // speed and mode registers
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      double_speed_bit_reg <= 1'b0;
      up_down_enable_reg   <= 1'b0;
      ctrl_reg             <= `TUD_RST_BYTE;
    end else begin
      if (wr_at(`TUD_ADR_SPEED)) begin
        double_speed_bit_reg <= I_SFR_WDATA[`TUD_B_DOUBLE];
      end
      if (wr_at(`TUD_ADR_MODE)) begin
        up_down_enable_reg <= I_SFR_WDATA[`TUD_B_UDEN];
      end
      if (wr_ctrl) begin
        ctrl_reg <= I_SFR_WDATA;
      end
    end
  end

  // overflow flag: hardware set beats software clear
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      overflow_flag_reg <= 1'b0;
    end else begin
      overflow_flag_reg <= (wr_ctrl ? I_SFR_WDATA[`TUD_B_OVF]
                                    : overflow_flag_reg) |
                           ((ovf_ev || unf_ev) && !baud);
    end
  end

  // external flag: toggle in up/down, set on pin fall otherwise
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      external_flag_reg <= 1'b0;
    end else begin
      external_flag_reg <= ((wr_ctrl ? I_SFR_WDATA[`TUD_B_EXT]
                                     : external_flag_reg) ^
                            (updown && (ovf_ev || unf_ev))) |
                           ext_ev;
    end
  end

  // baud rate overflow pulse toward serial port
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      baud_reg <= 1'b0;
    end else begin
      baud_reg <= ovf_ev && baud;
    end
  end

  // ************************************************************
  // read port
  // ************************************************************
  // registered read data, unmapped reads zero
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rdata_reg <= `TUD_RST_BYTE;
    end else if (I_SFR_RD) begin
      case (I_SFR_ADDR)
        `TUD_ADR_SPEED:  rdata_reg <= {7'h00, double_speed_bit_reg};
        `TUD_ADR_CTRL:   rdata_reg <= {overflow_flag_reg,
                                       external_flag_reg,
                                       ctrl_reg[5:0]};
        `TUD_ADR_MODE:   rdata_reg <= {7'h00, up_down_enable_reg};
        `TUD_ADR_RLD_LO: rdata_reg <= reload_low_byte_reg;
        `TUD_ADR_RLD_HI: rdata_reg <= reload_high_byte_reg;
        `TUD_ADR_CNT_LO: rdata_reg <= count_low_byte_reg;
        `TUD_ADR_CNT_HI: rdata_reg <= count_high_byte_reg;
        default:         rdata_reg <= `TUD_RST_BYTE;
      endcase
    end
  end

  // outputs
  assign O_SFR_RDATA    = rdata_reg;
  assign O_IRQ          = overflow_flag_reg |
                          (external_flag_reg & ~updown);
  assign O_BAUD_OVF     = baud_reg;
  assign O_DOUBLE_SPEED = double_speed_bit_reg;
  assign O_CORE_EN      = core_en;
  assign O_MC_TICK      = mc_tick;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  sequence s_up_ovf;
    ovf_ev && reload_mode && !wr_cnt && !wr_rlo && !wr_rhi;
  endsequence
  sequence s_dn_unf;
    unf_ev && !wr_cnt;
  endsequence

  property p_reload;
    s_up_ovf |=> cnt == $past(rld);
  endproperty
  a_reload: assert property (p_reload)
    else $error("overflow did not load reload value");

  property p_underflow;
    s_dn_unf |=> cnt == 16'hFFFF ##1 1'b1;
  endproperty
  a_underflow: assert property (p_underflow)
    else $error("underflow did not load all ones");

  property p_flag_set;
    (ovf_ev || unf_ev) && !baud |=> overflow_flag_reg && O_IRQ;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("overflow flag or request missing");

  property p_flag_baud;
    baud && !overflow_flag_reg && !wr_ctrl |=> !overflow_flag_reg;
  endproperty
  a_flag_baud: assert property (p_flag_baud)
    else $error("overflow flag set in baud mode");

  property p_flag_sticky;
    overflow_flag_reg && !wr_ctrl |=> overflow_flag_reg;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("overflow flag cleared by itself");

  property p_down_step;
    inc_ev && !dir_up && !unf_ev && !wr_cnt && !reload_ext
      |=> cnt == $past(cnt) - 16'h0001;
  endproperty
  a_down_step: assert property (p_down_step)
    else $error("down count did not step by one");

  property p_carry;
    inc_ev && dir_up && count_low_byte_reg == 8'hFF && !ovf_ev &&
      !wr_cnt && !reload_ext
      |=> count_low_byte_reg == 8'h00 &&
          count_high_byte_reg == $past(count_high_byte_reg) + 8'h01;
  endproperty
  a_carry: assert property (p_carry)
    else $error("low byte carry lost");

  property p_hold;
    !ctrl_reg[`TUD_B_RUN] && !wr_cnt && !reload_ext |=> $stable(cnt);
  endproperty
  a_hold: assert property (p_hold)
    else $error("count moved while stopped");

  property p_toggle;
    updown && (ovf_ev || unf_ev) && !wr_ctrl
      |=> external_flag_reg != $past(external_flag_reg);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("external flag did not toggle");

  property p_no_ext_irq;
    updown |-> O_IRQ == overflow_flag_reg;
  endproperty
  a_no_ext_irq: assert property (p_no_ext_irq)
    else $error("external flag raised a request");

  property p_write_wins;
    wr_lo |=> count_low_byte_reg == $past(I_SFR_WDATA);
  endproperty
  a_write_wins: assert property (p_write_wins)
    else $error("count write lost");

  property p_rsv_zero;
    I_SFR_RD && I_SFR_ADDR == `TUD_ADR_SPEED |=> O_SFR_RDATA[7:1] == 7'h00;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero)
    else $error("reserved speed bits not zero");
endmodule

//--- dv/tb.sv
// self-checking bench for the up/down auto-reload timer
// assumes the pin model drives the event and direction pins
`timescale 1ns/1ps
`include "tud_map.svh"
module tb;
  // ************************************************************
  // signals and instances
  // ************************************************************
  logic       clk;
  logic       rst;
  logic [7:0] addr;
  logic       wr;
  logic       rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       ev_pin;
  logic       dir_pin;
  logic       irq;
  logic       baud_ovf;
  logic       dbl;
  logic       core_en;
  logic       mc_tick;
  int         err_count    = 0;
  int         total_checks = 0;
  int         baud_cnt     = 0;
  logic [7:0] regs [8] = '{`TUD_ADR_SPEED, `TUD_ADR_CTRL, `TUD_ADR_MODE,
    `TUD_ADR_RLD_LO, `TUD_ADR_RLD_HI, `TUD_ADR_CNT_LO, `TUD_ADR_CNT_HI,
    8'h55};

  tud_timer dut (
    .I_CLK             (clk),
    .I_RST             (rst),
    .I_SFR_ADDR        (addr),
    .I_SFR_WR          (wr),
    .I_SFR_RD          (rd),
    .I_SFR_WDATA       (wdata),
    .O_SFR_RDATA       (rdata),
    .I_EVENT_COUNT_PIN (ev_pin),
    .I_DIRECTION_PIN   (dir_pin),
    .O_IRQ             (irq),
    .O_BAUD_OVF        (baud_ovf),
    .O_DOUBLE_SPEED    (dbl),
    .O_CORE_EN         (core_en),
    .O_MC_TICK         (mc_tick)
  );

  tud_pins_model pins (
    .i_clk   (clk),
    .o_event (ev_pin),
    .o_dir   (dir_pin)
  );

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // counts baud overflow pulses at settled points
  always @(negedge clk) begin
    if (baud_ovf === 1'b1) begin
      baud_cnt++;
    end
  end

  // ************************************************************
  // compare and access tasks
  // ************************************************************
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t byte %h exp %h", $time, got, exp);
    end
  endtask

  // flags, called only at a settled point
  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t flag %b exp %b", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    chk8(rdata, exp);
  endtask

  task automatic set16(input logic [7:0] lo_a, input logic [15:0] v);
    wr_reg(lo_a, v[7:0]);
    wr_reg(lo_a + 8'h01, v[15:8]);
  endtask

  task automatic rd16(input logic [7:0] lo_a, input logic [15:0] exp);
    rd_reg(lo_a, exp[7:0]);
    rd_reg(lo_a + 8'h01, exp[15:8]);
  endtask

  // core enables and machine ticks over a 48 clock window
  task automatic speed_chk(input int en_exp, input int tick_exp);
    int en_n = 0;
    int tk_n = 0;
    repeat (24) @(negedge clk);
    repeat (48) begin
      @(negedge clk);
      if (core_en === 1'b1) en_n++;
      if (mc_tick === 1'b1) tk_n++;
    end
    chk8(8'(en_n), 8'(en_exp));
    chk8(8'(tk_n), 8'(tick_exp));
  endtask

  // timer input run for a fixed span of clocks
  task automatic run_window(input int n);
    set16(`TUD_ADR_CNT_LO, 16'h0000);
    wr_reg(`TUD_ADR_CTRL, 8'h04);
    repeat (n) @(posedge clk);
    wr_reg(`TUD_ADR_CTRL, 8'h00);
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ************************************************************
  // watchdog
  // ************************************************************
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    test_done();
  end

  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    rst   = 1'b1;
    wr    = 1'b0;
    rd    = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // reset values, unmapped address reads zero
    foreach (regs[i]) rd_reg(regs[i], 8'h00);
    chk1(dbl, 1'b0);
    speed_chk(24, 2);
    // reserved speed bits written zero, double speed on
    wr_reg(`TUD_ADR_SPEED, 8'h01);
    rd_reg(`TUD_ADR_SPEED, 8'h01);
    chk1(dbl, 1'b1);
    speed_chk(48, 4);
    run_window(118);
    rd16(`TUD_ADR_CNT_LO, 16'h000A);
    // standard speed, 240 clocks give ten machine cycles
    wr_reg(`TUD_ADR_SPEED, 8'h00);
    run_window(238);
    rd16(`TUD_ADR_CNT_LO, 16'h000A);
    // stopped counter ignores events
    wr_reg(`TUD_ADR_CTRL, 8'h02);
    pins.gap = 2;
    pins.pulse_events(3);
    rd16(`TUD_ADR_CNT_LO, 16'h000A);
    pins.gap = 0;
    // counter mode: cascade carry, then overflow reload
    set16(`TUD_ADR_RLD_LO, 16'h1234);
    set16(`TUD_ADR_CNT_LO, 16'h00FF);
    wr_reg(`TUD_ADR_CTRL, 8'h06);
    pins.pulse_events(1);
    rd16(`TUD_ADR_CNT_LO, 16'h0100);
    set16(`TUD_ADR_CNT_LO, 16'hFFFF);
    pins.pulse_events(1);
    rd16(`TUD_ADR_CNT_LO, 16'h1234);
    rd_reg(`TUD_ADR_CTRL, 8'h86);
    chk1(irq, 1'b1);
    // up/down mode: count down to reload, then underflow
    wr_reg(`TUD_ADR_CTRL, 8'h02);
    wr_reg(`TUD_ADR_MODE, 8'h01);
    set16(`TUD_ADR_RLD_LO, 16'h1000);
    set16(`TUD_ADR_CNT_LO, 16'h1001);
    pins.set_dir(1'b0);
    wr_reg(`TUD_ADR_CTRL, 8'h06);
    pins.pulse_events(1);
    rd16(`TUD_ADR_CNT_LO, 16'h1000);
    pins.pulse_events(1);
    rd16(`TUD_ADR_CNT_LO, 16'hFFFF);
    rd_reg(`TUD_ADR_CTRL, 8'hC6);
    wr_reg(`TUD_ADR_CTRL, 8'h46);
    @(negedge clk);
    chk1(irq, 1'b0);
    pins.set_dir(1'b1);
    pins.pulse_events(1);
    rd16(`TUD_ADR_CNT_LO, 16'h1000);
    rd_reg(`TUD_ADR_CTRL, 8'h86);
    // classic reload on a direction fall
    wr_reg(`TUD_ADR_CTRL, 8'h02);
    wr_reg(`TUD_ADR_MODE, 8'h00);
    set16(`TUD_ADR_RLD_LO, 16'h2222);
    set16(`TUD_ADR_CNT_LO, 16'h0300);
    wr_reg(`TUD_ADR_CTRL, 8'h0E);
    pins.dir_fall();
    rd16(`TUD_ADR_CNT_LO, 16'h2222);
    rd_reg(`TUD_ADR_CTRL, 8'h4E);
    chk1(irq, 1'b1);
    // capture mode copies count into reload bytes
    wr_reg(`TUD_ADR_CTRL, 8'h0F);
    set16(`TUD_ADR_CNT_LO, 16'h4321);
    pins.dir_fall();
    rd16(`TUD_ADR_RLD_LO, 16'h4321);
    rd_reg(`TUD_ADR_CTRL, 8'h4F);
    // baud mode: reload and pulse, overflow flag stays clear
    wr_reg(`TUD_ADR_CTRL, 8'h26);
    set16(`TUD_ADR_RLD_LO, 16'h0055);
    set16(`TUD_ADR_CNT_LO, 16'hFFFF);
    baud_cnt = 0;
    pins.gap = 2;
    pins.pulse_events(1);
    rd16(`TUD_ADR_CNT_LO, 16'h0055);
    rd_reg(`TUD_ADR_CTRL, 8'h26);
    chk8(8'(baud_cnt), 8'h01);
    // transmit select is baud too: direction fall only flags
    wr_reg(`TUD_ADR_CTRL, 8'h1E);
    pins.dir_fall();
    rd16(`TUD_ADR_CNT_LO, 16'h0055);
    rd_reg(`TUD_ADR_CTRL, 8'h5E);
    // mid-run reset returns to standard speed and clear count
    wr_reg(`TUD_ADR_SPEED, 8'h01);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_reg(`TUD_ADR_SPEED, 8'h00);
    chk1(dbl, 1'b0);
    rd16(`TUD_ADR_CNT_LO, 16'h0000);
    rd_reg(`TUD_ADR_CTRL, 8'h00);
    test_done();
  end
endmodule

//--- dv/tud_pins_model.sv
// behavioural model of the event and direction pin drivers
// assumes the bench calls its tasks from one process at a time
`timescale 1ns/1ps
module tud_pins_model (
  // clock
  input  wire logic i_clk,
  // pins
  output logic      o_event,
  output logic      o_dir
);
  // idle cycles between events, raised for a slow far side
  int gap = 0;

  // ************************************************************
  // idle levels
  // ************************************************************
  // both pins idle high so no stray fall at start
  initial begin
    o_event = 1'b1;
    o_dir   = 1'b1;
  end

  // ************************************************************
  // pin stimulus
  // ************************************************************
  // one falling edge per event, high again before the next
  task automatic pulse_events(input int n);
    repeat (n) begin
      @(posedge i_clk);
      o_event <= 1'b0;
      @(posedge i_clk);
      o_event <= 1'b1;
      repeat (gap) @(posedge i_clk);
    end
  endtask

  // direction level, high counts up
  task automatic set_dir(input logic v);
    @(posedge i_clk);
    o_dir <= v;
  endtask

  // one falling edge on the direction pin, then back high
  task automatic dir_fall();
    @(posedge i_clk);
    o_dir <= 1'b0;
    @(posedge i_clk);
    o_dir <= 1'b1;
  endtask
endmodule
